// File: dsi2c_pkg.sv
// Purpose: shared constants and types of the deserializer i2c control target
// Assumes: system clock of 200 MHz; register offsets are i2c register addresses
// Notes: back-channel command kinds are shared with the bench; target states are used by the target alone
package dsi2c_pkg;
	// clock and strap settle timing
	localparam int CLK_HZ = 200_000_000;
	localparam int STRAP_WAIT_US = 1000; // 1 ms after power-down release
	localparam int STRAP_WAIT_CYC = (CLK_HZ / 1_000_000) * STRAP_WAIT_US;
	localparam int WAIT_W = 20;

	// register offsets
	localparam logic [7:0] REG_ID = 8'h00;
	localparam logic [7:0] REG_GEN = 8'h02;
	localparam logic [7:0] REG_PSEL = 8'h4C;
	localparam logic [7:0] REG_BCC = 8'h58;
	localparam logic [7:0] REG_ALIAS = 8'h5C;
	localparam logic [7:0] REG_DIR0 = 8'hF8;
	localparam logic [7:0] REG_DIR1 = 8'hF9;

	// field positions
	localparam int ID_OVR_BIT = 0;
	localparam int PROXY_EN_BIT = 5;
	localparam int PSEL_BIT = 0;
	localparam int PASS_BIT = 6;
	localparam int RATE_LSB = 0;
	localparam int RATE_W = 3;

	// back-channel rate codes
	localparam logic [2:0] RATE_2P5 = 3'h0;
	localparam logic [2:0] RATE_50 = 3'h2;

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// primary 7-bit address for each strap level
	localparam logic [6:0] ADDR_BY_STRAP [8] = '{7'h30, 7'h32, 7'h34, 7'h36,
		7'h38, 7'h3A, 7'h3C, 7'h3D};

	typedef enum logic [1:0] {
		DSI2C_BC_START = 2'b00,
		DSI2C_BC_WRITE = 2'b01,
		DSI2C_BC_READ = 2'b10,
		DSI2C_BC_STOP = 2'b11
	} dsi2c_bc_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ACK = 3'b010,
		ST_RX = 3'b011,
		ST_TX = 3'b100,
		ST_HACK = 3'b101,
		ST_WAIT = 3'b110,
		ST_SKIP = 3'b111
	} dsi2c_state_t;
endpackage

// File: dsi2c_target.sv
// Purpose: i2c configuration target of a dual-port deserializer hub with back channel
// Assumes: scl/sda/straps are asynchronous pins; bc_clk is the back-channel clock
// Notes: local accesses never stretch; forwarded bytes stretch scl until the reply
// Summary of operation
// [RULE1] target serves standard, fast and fast-plus bus speeds up to 1 MHz scl
// [RULE2] combined read/write with repeated start is forwarded to remote targets
// [RULE3] host ends each remote write to legacy serializers with stop, no restart
// [RULE4] local register accesses never hold scl low
// [RULE5] forwarded accesses hold scl low until the remote reply returns
// [RULE6] proxy controller acts on remote requests only while proxy enable is one
// [RULE7] host starts no link access while selected port lock is low
// [RULE8] back channel also carries gpio levels and capability code to serializer
// [RULE9] default rate comes from mode strap; per-port rate field overrides it
// [RULE10] two back-channel rates exist: 50 Mbps and 2.5 Mbps
// [RULE11] strap sampled 1 ms after power-down release goes high
// [RULE12] strap level 0..7 picks primary address 0x30..0x3C or 0x3D
// [RULE13] primary address is held in the identity register at offset zero
// [RULE14] two per-port addresses reach one port's registers without paging
// [RULE15] per-port addresses reach shared registers like the primary address
// [RULE16] port 0 direct address sits at 0xF8, port 1 at 0xF9
// [RULE17] host selects the carrying port in the port-select register first
// [RULE18] forwarding happens only while the pass-through bit is set
// [RULE19] own addresses are acknowledged, unknown addresses leave sda released
// [RULE20] all bus activity is ignored until the strap has been sampled
`timescale 1ns/100ps
module dsi2c_target #(
	parameter int STRAP_WAIT = dsi2c_pkg::STRAP_WAIT_CYC,
	parameter logic [7:0] CAPS = 8'h01 // arbitrary capability code
) (
	input logic sys_clk,
	input logic rstn,
	input logic power_down_release,
	input logic [2:0] address_strap_pin,
	input logic mode_strap,
	input logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input logic [1:0] port_lock,
	output logic [2:0] back_channel_rate_select0,
	output logic [2:0] back_channel_rate_select1,
	input logic [3:0] gpio_in,
	input logic bc_clk,
	output logic bc_tx_valid,
	output dsi2c_pkg::dsi2c_bc_kind_t bc_tx_kind,
	output logic bc_tx_port,
	output logic [7:0] bc_tx_data,
	input logic bc_rx_valid,
	input logic bc_rx_ack,
	input logic [7:0] bc_rx_data,
	input logic bc_remote_valid,
	input logic [7:0] bc_remote_data,
	output logic proxy_start,
	output logic [7:0] proxy_data,
	output logic [3:0] bc_gpio,
	output logic [7:0] bc_caps
);
	localparam logic [dsi2c_pkg::WAIT_W-1:0] WAIT_M1 = dsi2c_pkg::WAIT_W'(STRAP_WAIT - 1);

	typedef struct packed {
		logic scl_m;
		logic scl_s;
		logic scl_d;
		logic sda_m;
		logic sda_s;
		logic sda_d;
		logic pdr_m;
		logic pdr_s;
		logic mode_m;
		logic mode_s;
		logic [2:0] strap_m;
		logic [2:0] strap_s;
		logic [1:0] lock_m;
		logic [1:0] lock_s;
		logic rsp_m;
		logic rsp_s;
		logic [dsi2c_pkg::WAIT_W-1:0] wait_cnt;
		logic ready;
		dsi2c_pkg::dsi2c_state_t st;
		logic [3:0] cnt;
		logic [7:0] sr;
		logic remote;
		logic rd;
		logic first;
		logic ackd;
		logic page;
		logic [7:0] ptr;
		logic sda_oe;
		logic scl_oe;
		logic [6:0] prim;
		logic proxy_en;
		logic port_sel;
		logic [1:0][7:0] cfg;
		logic [1:0][7:0] alias_r;
		logic [1:0][7:0] dir;
		logic req_tg;
		dsi2c_pkg::dsi2c_bc_kind_t req_kind;
		logic req_port;
		logic [7:0] req_data;
	} dsi2c_sys_t;

	typedef struct packed {
		logic rst_m;
		logic rst_s;
		logic req_m;
		logic req_s;
		logic req_d;
		logic pe_m;
		logic pe_s;
		logic [3:0] gpio_m;
		logic [3:0] gpio_s;
		logic [3:0] gpio;
		logic busy;
		logic rsp_tg;
		logic rsp_ack;
		logic [7:0] rsp_data;
		logic tx_valid;
		dsi2c_pkg::dsi2c_bc_kind_t tx_kind;
		logic tx_port;
		logic [7:0] tx_data;
		logic proxy_start;
		logic [7:0] proxy_data;
	} dsi2c_link_t;

	dsi2c_sys_t s;
	dsi2c_sys_t nx;
	dsi2c_link_t l;
	dsi2c_link_t nl;

	// register read decode, paged by the access page
	function automatic logic [7:0] reg_rd(dsi2c_sys_t x, logic pg, logic [7:0] a);
		logic [7:0] r;
		r = dsi2c_pkg::BYTE_ZERO;
		case (a)
			dsi2c_pkg::REG_ID: r = {x.prim, 1'b0}; // RULE13
			dsi2c_pkg::REG_GEN: r[dsi2c_pkg::PROXY_EN_BIT] = x.proxy_en;
			dsi2c_pkg::REG_PSEL: r[dsi2c_pkg::PSEL_BIT] = x.port_sel;
			dsi2c_pkg::REG_BCC: r = x.cfg[pg];
			dsi2c_pkg::REG_ALIAS: r = x.alias_r[pg];
			dsi2c_pkg::REG_DIR0: r = x.dir[0];
			dsi2c_pkg::REG_DIR1: r = x.dir[1];
			default: r = dsi2c_pkg::BYTE_ZERO;
		endcase
		return r;
	endfunction

	// programmable address match, zero means unused
	function automatic logic amatch(logic [7:0] v, logic [7:0] b);
		return (v != dsi2c_pkg::BYTE_ZERO) && (v[7:1] == b[7:1]);
	endfunction

	// post a back-channel command and hold scl low for the reply
	function automatic dsi2c_sys_t issue(dsi2c_sys_t x, dsi2c_pkg::dsi2c_bc_kind_t k,
		logic [7:0] d);
		dsi2c_sys_t y;
		y = x;
		y.req_tg = ~x.req_tg;
		y.req_kind = k;
		y.req_data = d;
		y.req_port = x.port_sel;
		y.scl_oe = 1'b1; // RULE5
		y.st = dsi2c_pkg::ST_WAIT;
		return y;
	endfunction

	// i2c target, strap capture and register file
	always_comb begin
		logic rise;
		logic fall;
		logic start;
		logic stop;
		logic next_rd;
		logic hit;
		logic [2:0] rate;
		logic [7:0] rdat;
		rise = s.scl_s & ~s.scl_d;
		fall = ~s.scl_s & s.scl_d;
		start = s.scl_s & s.scl_d & s.sda_d & ~s.sda_s;
		stop = s.scl_s & s.scl_d & ~s.sda_d & s.sda_s;
		next_rd = 1'b0;
		hit = 1'b0;
		rate = s.mode_s ? dsi2c_pkg::RATE_50 : dsi2c_pkg::RATE_2P5; // RULE9 RULE10
		rdat = reg_rd(s, s.page, s.ptr);
		nx = s;
		nx.scl_oe = 1'b0; // RULE4
		if (!s.ready) begin
			// bus ignored until the strap is captured
			nx.st = dsi2c_pkg::ST_IDLE; // RULE20
			nx.sda_oe = 1'b0;
			if (s.pdr_s) begin
				if (s.wait_cnt == WAIT_M1) begin
					nx.ready = 1'b1; // RULE11
					nx.prim = dsi2c_pkg::ADDR_BY_STRAP[s.strap_s]; // RULE12
					nx.cfg[0][dsi2c_pkg::RATE_LSB +: dsi2c_pkg::RATE_W] = rate;
					nx.cfg[1][dsi2c_pkg::RATE_LSB +: dsi2c_pkg::RATE_W] = rate;
				end else begin
					nx.wait_cnt = s.wait_cnt + 1'b1;
				end
			end
		end else if (start) begin
			// start or repeated start
			nx.st = dsi2c_pkg::ST_ADDR; // RULE2
			nx.cnt = 4'h0;
			nx.sda_oe = 1'b0;
		end else if (stop) begin
			if (s.remote) begin
				nx = issue(nx, dsi2c_pkg::DSI2C_BC_STOP, dsi2c_pkg::BYTE_ZERO);
			end
			nx.st = dsi2c_pkg::ST_IDLE;
			nx.remote = 1'b0;
			nx.sda_oe = 1'b0;
			nx.scl_oe = 1'b0;
		end else begin
			unique case (s.st)
				dsi2c_pkg::ST_IDLE, dsi2c_pkg::ST_SKIP: begin
					nx.sda_oe = 1'b0; // RULE19
				end
				dsi2c_pkg::ST_ADDR, dsi2c_pkg::ST_RX: begin
					if (rise) begin
						nx.sr = {s.sr[6:0], s.sda_s};
						nx.cnt = s.cnt + 1'b1;
					end
					if (fall && s.cnt == dsi2c_pkg::BITS_PER_BYTE) begin
						nx.cnt = 4'h0;
						if (s.st == dsi2c_pkg::ST_ADDR) begin
							// address decode
							nx.rd = s.sr[0];
							nx.first = ~s.sr[0];
							if (s.sr[7:1] == s.prim) begin
								hit = 1'b1; // RULE19
								nx.page = s.port_sel;
							end else if (amatch(s.dir[0], s.sr)) begin
								hit = 1'b1; // RULE14 RULE15 RULE16
								nx.page = 1'b0;
							end else if (amatch(s.dir[1], s.sr)) begin
								hit = 1'b1; // RULE14 RULE15 RULE16
								nx.page = 1'b1;
							end
							if (hit) begin
								nx.remote = 1'b0;
								nx.sda_oe = 1'b1;
								nx.ackd = 1'b1;
								nx.st = dsi2c_pkg::ST_ACK;
							end else if (amatch(s.alias_r[s.port_sel], s.sr) &&
								s.cfg[s.port_sel][dsi2c_pkg::PASS_BIT] && // RULE18
								s.lock_s[s.port_sel]) begin // RULE7 RULE17
								nx.remote = 1'b1;
								nx = issue(nx, dsi2c_pkg::DSI2C_BC_START, s.sr);
							end else begin
								nx.st = dsi2c_pkg::ST_SKIP; // RULE19
							end
						end else if (s.remote) begin
							nx = issue(nx, dsi2c_pkg::DSI2C_BC_WRITE, s.sr);
						end else begin
							// pointer byte first, then data with auto increment
							if (s.first) begin
								nx.ptr = s.sr;
								nx.first = 1'b0;
							end else begin
								nx.ptr = s.ptr + 1'b1;
								case (s.ptr)
									dsi2c_pkg::REG_ID: begin
										if (s.sr[dsi2c_pkg::ID_OVR_BIT]) begin
											nx.prim = s.sr[7:1];
										end
									end
									dsi2c_pkg::REG_GEN: nx.proxy_en = s.sr[dsi2c_pkg::PROXY_EN_BIT];
									dsi2c_pkg::REG_PSEL: nx.port_sel = s.sr[dsi2c_pkg::PSEL_BIT];
									dsi2c_pkg::REG_BCC: nx.cfg[s.page] = s.sr; // RULE9
									dsi2c_pkg::REG_ALIAS: nx.alias_r[s.page] = s.sr;
									dsi2c_pkg::REG_DIR0: nx.dir[0] = s.sr; // RULE16
									dsi2c_pkg::REG_DIR1: nx.dir[1] = s.sr; // RULE16
									default: ;
								endcase
							end
							nx.sda_oe = 1'b1;
							nx.ackd = 1'b1;
							nx.st = dsi2c_pkg::ST_ACK;
						end
					end
				end
				dsi2c_pkg::ST_ACK: begin
					if (fall) begin
						nx.sda_oe = 1'b0;
						nx.cnt = 4'h0;
						if (!s.ackd) begin
							nx.st = dsi2c_pkg::ST_SKIP;
						end else if (s.rd) begin
							next_rd = 1'b1;
						end else begin
							nx.st = dsi2c_pkg::ST_RX;
						end
					end
				end
				dsi2c_pkg::ST_TX: begin
					if (rise) begin
						nx.cnt = s.cnt + 1'b1;
					end
					if (fall) begin
						if (s.cnt == dsi2c_pkg::BITS_PER_BYTE) begin
							nx.sda_oe = 1'b0;
							nx.cnt = 4'h0;
							nx.st = dsi2c_pkg::ST_HACK;
						end else begin
							nx.sr = {s.sr[6:0], 1'b0};
							nx.sda_oe = ~s.sr[6];
						end
					end
				end
				dsi2c_pkg::ST_HACK: begin
					if (rise && s.sda_s) begin
						nx.st = dsi2c_pkg::ST_SKIP; // host nack ends the read
					end
					if (fall) begin
						next_rd = 1'b1;
					end
				end
				dsi2c_pkg::ST_WAIT: begin
					nx.scl_oe = 1'b1; // RULE5
					if (s.rsp_s == s.req_tg) begin
						if (s.req_kind == dsi2c_pkg::DSI2C_BC_READ) begin
							nx.sr = l.rsp_data;
							nx.sda_oe = ~l.rsp_data[7];
							nx.cnt = 4'h0;
							nx.st = dsi2c_pkg::ST_TX;
						end else begin
							nx.ackd = l.rsp_ack;
							nx.sda_oe = l.rsp_ack;
							nx.st = dsi2c_pkg::ST_ACK;
						end
					end
				end
			endcase
			// fetch the next read byte
			if (next_rd) begin
				nx.cnt = 4'h0;
				if (s.remote) begin
					nx = issue(nx, dsi2c_pkg::DSI2C_BC_READ, dsi2c_pkg::BYTE_ZERO);
				end else begin
					nx.sr = rdat;
					nx.sda_oe = ~rdat[7];
					nx.ptr = s.ptr + 1'b1;
					nx.st = dsi2c_pkg::ST_TX;
				end
			end
		end
		// power-down low acts as reset; handshake fields survive
		if (!s.pdr_s) begin
			nx = '0;
			nx.req_tg = s.req_tg;
			nx.req_kind = s.req_kind;
			nx.req_port = s.req_port;
			nx.req_data = s.req_data;
		end
		// pin and cross-domain synchronisers
		nx.scl_m = scl_i; // RULE1
		nx.scl_s = s.scl_m;
		nx.scl_d = s.scl_s;
		nx.sda_m = sda_i;
		nx.sda_s = s.sda_m;
		nx.sda_d = s.sda_s;
		nx.pdr_m = power_down_release;
		nx.pdr_s = s.pdr_m;
		nx.mode_m = mode_strap;
		nx.mode_s = s.mode_m;
		nx.strap_m = address_strap_pin;
		nx.strap_s = s.strap_m;
		nx.lock_m = port_lock;
		nx.lock_s = s.lock_m;
		nx.rsp_m = l.rsp_tg;
		nx.rsp_s = s.rsp_m;
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= nx;
		end
	end

	// back-channel side: commands out, replies in, proxy and gpio
	always_comb begin
		nl = l;
		nl.tx_valid = 1'b0;
		nl.proxy_start = 1'b0;
		if (l.req_s != l.req_d) begin
			nl.req_d = l.req_s;
			nl.tx_valid = 1'b1;
			nl.tx_kind = s.req_kind;
			nl.tx_port = s.req_port;
			nl.tx_data = s.req_data;
			if (s.req_kind == dsi2c_pkg::DSI2C_BC_STOP) begin
				nl.rsp_tg = ~l.rsp_tg;
			end else begin
				nl.busy = 1'b1;
			end
		end
		if (l.busy && bc_rx_valid) begin
			nl.busy = 1'b0;
			nl.rsp_ack = bc_rx_ack;
			nl.rsp_data = bc_rx_data;
			nl.rsp_tg = ~l.rsp_tg;
		end
		if (bc_remote_valid && l.pe_s) begin
			nl.proxy_start = 1'b1; // RULE6
			nl.proxy_data = bc_remote_data;
		end
		nl.gpio = l.gpio_s; // RULE8
		if (!l.rst_s) begin
			nl = '0;
		end
		nl.rst_m = rstn;
		nl.rst_s = l.rst_m;
		nl.req_m = s.req_tg;
		nl.req_s = l.req_m;
		nl.pe_m = s.proxy_en;
		nl.pe_s = l.pe_m;
		nl.gpio_m = gpio_in;
		nl.gpio_s = l.gpio_m;
	end

	always_ff @(posedge bc_clk) begin
		l <= nl;
	end

	// open-drain pins drive low only
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = s.scl_oe;
	assign sda_oe = s.sda_oe;
	assign back_channel_rate_select0 = s.cfg[0][dsi2c_pkg::RATE_LSB +: dsi2c_pkg::RATE_W];
	assign back_channel_rate_select1 = s.cfg[1][dsi2c_pkg::RATE_LSB +: dsi2c_pkg::RATE_W];
	assign bc_tx_valid = l.tx_valid;
	assign bc_tx_kind = l.tx_kind;
	assign bc_tx_port = l.tx_port;
	assign bc_tx_data = l.tx_data;
	assign proxy_start = l.proxy_start;
	assign proxy_data = l.proxy_data;
	assign bc_gpio = l.gpio;
	assign bc_caps = CAPS; // RULE8
endmodule

// File: dsi2c_target_checker.sv
// Purpose: port checks of the deserializer i2c control target
// Assumes: scl_i and sda_i carry the resolved bus levels
// Notes: bound to every target instance
`timescale 1ns/100ps
module dsi2c_target_checker (
	input logic sys_clk,
	input logic rstn,
	input logic bc_clk,
	input logic power_down_release,
	input logic scl_i,
	input logic scl_oe,
	input logic sda_oe,
	input logic bc_tx_valid,
	input logic bc_remote_valid,
	input logic proxy_start,
	input logic [3:0] gpio_in,
	input logic [3:0] bc_gpio
);
	// held power-down leaves the bus alone
	property p_pdr;
		@(posedge sys_clk) disable iff (!rstn) !power_down_release [*4] |=> !scl_oe && !sda_oe;
	endproperty
	a_pdr: assert property (p_pdr) else $error("bus driven in power-down");
	// sda only moves while scl is low
	property p_sda;
		@(posedge sys_clk) disable iff (!rstn) $changed(sda_oe) |-> !scl_i;
	endproperty
	a_sda: assert property (p_sda) else $error("sda moved with scl high");
	// a stretch begins in the low phase
	property p_hold;
		@(posedge sys_clk) disable iff (!rstn) $rose(scl_oe) |-> !$past(scl_i);
	endproperty
	a_hold: assert property (p_hold) else $error("stretch began in high phase");
	// sda is settled one cycle before scl is let go
	property p_free;
		@(posedge sys_clk) disable iff (!rstn) $fell(scl_oe) |-> $stable(sda_oe);
	endproperty
	a_free: assert property (p_free) else $error("sda moved at stretch end");
	// a stretch always sends a link command
	property p_fwd;
		@(posedge sys_clk) disable iff (!rstn) $rose(scl_oe) |-> ##[1:300] bc_tx_valid;
	endproperty
	a_fwd: assert property (p_fwd) else $error("stretch without command");
	// commands are single link-cycle pulses
	property p_cmd;
		@(posedge bc_clk) disable iff (!rstn) bc_tx_valid |=> !bc_tx_valid;
	endproperty
	a_cmd: assert property (p_cmd) else $error("command pulse too long");
	// proxy start follows a remote request
	property p_prx;
		@(posedge bc_clk) disable iff (!rstn) proxy_start |-> $past(bc_remote_valid);
	endproperty
	a_prx: assert property (p_prx) else $error("proxy start without request");
	// gpio levels reach the link three link cycles late
	property p_gpio;
		@(posedge bc_clk) disable iff (!rstn) bc_gpio == $past(gpio_in, 3);
	endproperty
	a_gpio: assert property (p_gpio) else $error("gpio level lost");
endmodule

bind dsi2c_target dsi2c_target_checker u_chk (
	.sys_clk(sys_clk), .rstn(rstn), .bc_clk(bc_clk),
	.power_down_release(power_down_release), .scl_i(scl_i), .scl_oe(scl_oe),
	.sda_oe(sda_oe), .bc_tx_valid(bc_tx_valid), .bc_remote_valid(bc_remote_valid),
	.proxy_start(proxy_start), .gpio_in(gpio_in), .bc_gpio(bc_gpio)
);

// File: dsi2c_host.sv
// Purpose: behavioural i2c host controller on the local bus
// Assumes: the bench resolves the open-drain lines
// Notes: 1 MHz scl; waits out stretching and counts it
`timescale 1ns/100ps
module dsi2c_host (
	input logic sys_clk,
	input logic scl,
	input logic sda,
	output logic scl_h,
	output logic sda_h
);
	localparam int HQ = 100; // half scl period in cycles
	int stretch = 0;
	int stuck = 0;
	// idle bus
	initial begin
		scl_h = 1'b1;
		sda_h = 1'b1;
	end
	// wait on falling edges
	task automatic tw(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// release scl and tolerate a bounded stretch
	task automatic hi();
		int k;
		scl_h = 1'b1;
		tw(1);
		for (k = 0; k < 2000 && scl !== 1'b1; k++) tw(1);
		if (k > 0) stretch++;
		if (scl !== 1'b1) stuck++; // stretch limit ran out
		tw(HQ / 2);
	endtask
	// one bit, read back mid high
	task automatic bx(input logic b, output logic r);
		tw(4);
		sda_h = b;
		tw(HQ);
		hi();
		r = sda;
		tw(HQ / 2);
		scl_h = 1'b0;
	endtask
	// start or repeated start
	task automatic start();
		tw(4);
		sda_h = 1'b1;
		tw(HQ);
		hi();
		sda_h = 1'b0;
		tw(HQ / 2);
		scl_h = 1'b0;
	endtask
	// stop
	task automatic stop();
		tw(4);
		sda_h = 1'b0;
		tw(HQ);
		hi();
		sda_h = 1'b1;
		tw(HQ);
	endtask
	// byte out, msb first
	task automatic wb(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bx(d[i], r);
		bx(1'b1, r);
		ack = !r;
	endtask
	// byte in, then ack or nack
	task automatic rb(output logic [7:0] d, input logic last);
		logic r;
		for (int i = 7; i >= 0; i--) bx(1'b1, d[i]);
		bx(last, r);
	endtask
endmodule

// File: dsi2c_target_tb.sv
// Purpose: self-checking bench of the deserializer i2c control target
// Assumes: strap wait shortened to 20 cycles
// Notes: link far end answers each command except stop after 1 to 4 link cycles
`timescale 1ns/100ps
module dsi2c_target_tb;
	logic sys_clk = 1'b0, bc_clk = 1'b0, rstn = 1'b0, pdr = 1'b0, mode = 1'b0;
	logic rxv = 1'b0, remv = 1'b0, rack = 1'b1, scl_h, sda_h, scl_oe, sda_oe, txv, txp, pxs;
	logic [2:0] strap = 3'h0, rs0, rs1;
	logic [1:0] lock = 2'h3;
	logic [3:0] gpio = 4'h0;
	logic [7:0] rdat = 8'h00, remd = 8'h00, txd, pxd, caps;
	logic [31:0] seed = 32'hbb0a_2a4b;
	logic [10:0] log_q[$];
	int n_mismatch = 0, compares = 0, dly = 0, npx = 0;
	dsi2c_pkg::dsi2c_bc_kind_t txk;
	wire scl = scl_h & ~scl_oe;
	wire sda = sda_h & ~sda_oe;
	// clocks, link clock unrelated in phase
	initial forever #2.5 sys_clk = ~sys_clk;
	initial begin
		#1.3;
		forever #80 bc_clk = ~bc_clk;
	end
	dsi2c_target #(.STRAP_WAIT(20), .CAPS(8'h5A)) u_dsi2c_target (.sys_clk, .rstn,
		.power_down_release(pdr), .address_strap_pin(strap), .mode_strap(mode),
		.scl_i(scl), .scl_o(), .scl_oe, .sda_i(sda), .sda_o(), .sda_oe, .port_lock(lock),
		.back_channel_rate_select0(rs0), .back_channel_rate_select1(rs1), .gpio_in(gpio),
		.bc_clk, .bc_tx_valid(txv), .bc_tx_kind(txk), .bc_tx_port(txp), .bc_tx_data(txd),
		.bc_rx_valid(rxv), .bc_rx_ack(rack), .bc_rx_data(rdat), .bc_remote_valid(remv),
		.bc_remote_data(remd), .proxy_start(pxs), .proxy_data(pxd), .bc_gpio(), .bc_caps(caps));
	dsi2c_host u_dsi2c_host (.sys_clk, .scl, .sda, .scl_h, .sda_h);
	// random source
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	// expected primary address per strap level
	function automatic logic [6:0] pa(input logic [2:0] s);
		logic [6:0] t[8] = '{7'h30, 7'h32, 7'h34, 7'h36, 7'h38, 7'h3A, 7'h3C, 7'h3D};
		return t[s];
	endfunction
	// expected default rate of the mode strap
	function automatic logic [2:0] dr(input logic m);
		return m ? 3'h2 : 3'h0;
	endfunction
	// link far end: log commands, answer late
	always @(negedge bc_clk) begin
		rxv <= 1'b0;
		if (txv === 1'b1) begin
			log_q.push_back({txk, txp, txd});
			if (txk !== dsi2c_pkg::DSI2C_BC_STOP) dly = 1 + int'(rnd() & 32'h3);
		end else if (dly > 0) begin
			dly--;
			if (dly == 0) rxv <= 1'b1;
		end
	end
	// count proxy starts
	always @(negedge bc_clk) if (pxs === 1'b1) npx <= npx + 1;
	// compare and report
	task automatic chk(input logic [10:0] g, input logic [10:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// verdict
	task automatic test_done();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// register write through a device address
	task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
		logic k;
		u_dsi2c_host.start();
		u_dsi2c_host.wb({a, 1'b0}, k);
		u_dsi2c_host.wb(r, k);
		u_dsi2c_host.wb(d, k);
		chk(k, 1);
		u_dsi2c_host.stop();
	endtask
	// register read, pointer set by repeated start if p
	task automatic rdr(input logic [6:0] a, input logic p, input logic [7:0] e);
		logic k;
		logic [7:0] d;
		u_dsi2c_host.start();
		if (p) begin
			u_dsi2c_host.wb({a, 1'b0}, k);
			u_dsi2c_host.wb(8'h00, k);
			u_dsi2c_host.start();
		end
		u_dsi2c_host.wb({a, 1'b1}, k);
		chk(k, 1);
		u_dsi2c_host.rb(d, 1'b1);
		chk(d, e);
		u_dsi2c_host.stop();
	endtask
	// address that must not be acknowledged
	task automatic nak(input logic [6:0] a);
		logic k;
		u_dsi2c_host.start();
		u_dsi2c_host.wb({a, 1'b0}, k);
		chk(k, 0);
		u_dsi2c_host.stop();
	endtask
	// one remote request at the link
	task automatic prx();
		logic [31:0] v;
		repeat (6) @(negedge bc_clk);
		v = rnd();
		remd = v[7:0];
		remv = 1'b1;
		@(negedge bc_clk);
		remv = 1'b0;
		repeat (4) @(negedge bc_clk);
	endtask
	// hang guard
	initial begin
		#600000; // about 1.1 times the span of the full sequence
		n_mismatch++;
		test_done();
	end
	// main sequence
	initial begin
		logic k;
		logic [7:0] d, x;
		logic [31:0] rv;
		repeat (5) @(negedge bc_clk);
		rstn = 1'b1;
		u_dsi2c_host.start();
		pdr = 1'b1;
		u_dsi2c_host.wb({pa(3'h0), 1'b0}, k);
		chk(k, 0);
		u_dsi2c_host.stop();
		$display("test power-up done");
		for (int s = 0; s < 8; s++) begin
			rv = rnd();
			mode = rv[0];
			gpio = rv[4:1];
			strap = 3'(s);
			pdr = 1'b0;
			u_dsi2c_host.tw(4);
			pdr = 1'b1;
			u_dsi2c_host.tw(40);
			chk(rs0, dr(mode));
			chk(rs1, dr(mode));
			rdr(pa(strap), 1'b0, {pa(strap), 1'b0});
		end
		$display("test straps done");
		rv = rnd();
		nak({1'b1, rv[5:0]});
		wr(7'h3D, 8'hF8, 8'hA0);
		wr(7'h3D, 8'hF9, 8'hA2);
		wr(7'h51, 8'h58, {5'h00, rv[8:6]});
		chk(rs1, rv[8:6]);
		chk(rs0, dr(mode));
		wr(7'h50, 8'h58, {5'h08, rv[11:9]});
		chk(rs0, rv[11:9]);
		wr(7'h50, 8'h5C, 8'hC0);
		rdr(7'h51, 1'b1, 8'h7A);
		chk(11'(u_dsi2c_host.stretch), 0);
		$display("test direct done");
		rdat = rv[23:16];
		d = rv[31:24];
		u_dsi2c_host.start();
		u_dsi2c_host.wb(8'hC0, k);
		chk(k, 1);
		u_dsi2c_host.wb(d, k);
		u_dsi2c_host.start();
		u_dsi2c_host.wb(8'hC1, k);
		u_dsi2c_host.rb(x, 1'b1);
		chk(x, rdat);
		u_dsi2c_host.stop();
		repeat (10) @(negedge bc_clk);
		chk(11'(u_dsi2c_host.stretch != 0), 1);
		chk(11'(log_q.size()), 5);
		chk(log_q[0], 11'h0C0);
		chk(log_q[1], {3'h2, d});
		chk(log_q[2], 11'h0C1);
		chk(11'(log_q[3][10:8]), 11'h4);
		chk(11'(log_q[4][10:8]), 11'h6);
		// remote nack on the address must reach the host as nack
		rack = 1'b0;
		nak(7'h60);
		rack = 1'b1;
		wr(7'h50, 8'h58, {5'h00, rv[11:9]});
		nak(7'h60);
		$display("test remote done");
		wr(7'h3D, 8'h02, 8'h20);
		prx();
		chk(11'(npx), 1);
		chk(pxd, remd);
		wr(7'h3D, 8'h02, 8'h00);
		prx();
		chk(11'(npx), 1);
		chk(caps, 8'h5A);
		chk(11'(u_dsi2c_host.stuck), 0);
		$display("test proxy done");
		test_done();
	end
endmodule
